// ===== qdsl_pkg.sv
// Purpose: Shared constants for the quad DAC serial loader
// Assumes: 11-bit command word, channel select first, data MSB first
// Notes:   Field positions index the assembled shift word
package qdsl_pkg;
    localparam int WORD_BITS     = 11;
    localparam int DATA_BITS     = 8;
    localparam int SEL_BITS      = 2;
    localparam int NUM_CHANNELS  = 4;
    localparam int SEL_MSB       = 10;
    localparam int SEL_LSB       = 9;
    localparam int RANGE_POS     = 8;
    localparam int DATA_MSB      = 7;
    localparam int DATA_LSB      = 0;
    localparam logic [7:0]  CODE_RESET  = 8'h00;
    localparam logic        RANGE_RESET = 1'h0;
    localparam logic [10:0] WORD_RESET  = 11'h000;
    localparam logic [1:0]  SEL_A       = 2'h0;
    localparam logic [1:0]  SEL_B       = 2'h1;
    localparam logic [1:0]  SEL_C       = 2'h2;
    localparam logic [1:0]  SEL_D       = 2'h3;
    localparam logic [1:0]  SYNC_RESET  = 2'h0;
    localparam logic [1:0]  LATCH_IDLE  = 2'h3;
endpackage : qdsl_pkg

// ===== qdsl_shifter.sv
// Purpose: Serial shift register on the link clock domain
// Assumes: Host keeps the word-latch strobe high while shifting
// Notes:   Captures on falling serial clock; word held until next shift
`timescale 1ns/1ps
module qdsl_shifter
    import qdsl_pkg::*;
(
    input  wire logic                   serialClk,
    input  wire logic                   serialData,
    input  wire logic                   linkRst,
    output logic [WORD_BITS-1:0]        shiftWord
);
    logic [WORD_BITS-1:0] next_shiftWord;

    // Shift in MSB first, one bit per edge
    always_comb
    begin
        next_shiftWord = {shiftWord[WORD_BITS-2:0], serialData};
        if (linkRst)
        begin
            next_shiftWord = WORD_RESET;
        end
    end

    // Falling edge capture
    always_ff @(negedge serialClk)
    begin
        shiftWord <= next_shiftWord;
    end
endmodule : qdsl_shifter

// ===== qdsl_loader.sv
// Purpose: Quad DAC digital front end: serial word, two latch stages
// Assumes: Word stays stable while the word-latch strobe is low
// Notes:   Strobes are synchronised into sys_clk before use
//          The link reset is resynchronised on the serial clock
//          Both latch stages clear on rst
`timescale 1ns/1ps

// Notes on behaviour
// - A command word is 11 bits: 8-bit code, 2-bit channel select and one range bit.
// - The range bit sets the selected channel span to one or two times its reference.
// - One data bit is captured on each falling serial clock edge, the host presenting it before.
// - With the update strobe low, a falling word-latch strobe moves the word to the channel's output latch.
// - With the update strobe high, no channel output changes while words are loaded.
// - Outputs update from staged data only on a high-to-low update strobe transition.
// - On that transition all four outputs refresh together from their staged values.
// - Each channel has a staging latch and an output latch.
// - Reset puts every latch and output in a defined state.
// - Four independent channels each have their own code and reference.
module qdsl_loader
    import qdsl_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   serialClk,
    input  wire logic                   serialData,
    input  wire logic                   wordLatch,
    input  wire logic                   output_update_strobe,
    output logic [DATA_BITS-1:0]        analog_out_a,
    output logic [DATA_BITS-1:0]        analog_out_b,
    output logic [DATA_BITS-1:0]        analog_out_c,
    output logic [DATA_BITS-1:0]        analog_out_d,
    output logic                        rangeDouble_a,
    output logic                        rangeDouble_b,
    output logic                        rangeDouble_c,
    output logic                        rangeDouble_d
);
    logic [WORD_BITS-1:0]  shiftWord;
    logic [WORD_BITS-1:0]  wordSync1;
    logic [WORD_BITS-1:0]  wordSync2;
    logic [1:0]            latchSync;
    logic [1:0]            updSync;
    logic                  latchPrev;
    logic                  updPrev;
    logic [DATA_BITS-1:0]  stageCode   [NUM_CHANNELS];
    logic                  stageRange  [NUM_CHANNELS];
    logic [DATA_BITS-1:0]  outCode     [NUM_CHANNELS];
    logic                  outRange    [NUM_CHANNELS];
    logic [DATA_BITS-1:0]  next_stageCode  [NUM_CHANNELS];
    logic                  next_stageRange [NUM_CHANNELS];
    logic [DATA_BITS-1:0]  next_outCode    [NUM_CHANNELS];
    logic                  next_outRange   [NUM_CHANNELS];
    logic                  latchFall;
    logic                  updFall;
    logic [SEL_BITS-1:0]   selChan;
    logic [1:0]            linkRstSync;
    logic                  linkRst;
    // Next values of synchroniser state
    logic [1:0]            next_linkRstSync;
    logic [1:0]            next_latchSync;
    logic [1:0]            next_updSync;
    logic                  next_latchPrev;
    logic                  next_updPrev;
    logic [WORD_BITS-1:0]  next_wordSync1;
    logic [WORD_BITS-1:0]  next_wordSync2;

    // Output code field of a command word
    function automatic logic [DATA_BITS-1:0] wordCode(input logic [WORD_BITS-1:0] w);
        return w[DATA_MSB:DATA_LSB];
    endfunction : wordCode

    // Range field, set for twice the reference span
    function automatic logic wordRange(input logic [WORD_BITS-1:0] w);
        return w[RANGE_POS];
    endfunction : wordRange

    // Select field decode, codes 0 to 3 are channels A to D
    function automatic logic chanHit(input logic [SEL_BITS-1:0] sel, input int idx);
        return sel == SEL_BITS'(idx);
    endfunction : chanHit

    // Sys-domain reset taken into the link domain by two flops
    always_comb
    begin
        next_linkRstSync = {linkRstSync[0], rst};
    end

    // Link reset flops, on the capture edge of the link clock
    always_ff @(negedge serialClk)
    begin
        linkRstSync <= next_linkRstSync;
    end

    // Shifter reset reads only the second flop
    assign linkRst = linkRstSync[1];

    // Shift register on the serial clock
    qdsl_shifter u_shifter
    (
        .serialClk  (serialClk),
        .serialData (serialData),
        .linkRst    (linkRst),
        .shiftWord  (shiftWord)
    );

    // Next values of strobe synchronisers and word capture
    // Word bus is quasi-static: it stands for cycles before the strobe falls
    always_comb
    begin
        next_latchSync = {latchSync[0], wordLatch};
        next_updSync   = {updSync[0], output_update_strobe};
        next_latchPrev = latchSync[1];
        next_updPrev   = updSync[1];
        next_wordSync1 = shiftWord;
        next_wordSync2 = wordSync1;
        if (rst)
        begin
            next_latchSync = LATCH_IDLE; // Matches idle-high pin, no false fall
            next_updSync   = SYNC_RESET;
            next_latchPrev = 1'h1;
            next_updPrev   = 1'h0;
            next_wordSync1 = WORD_RESET;
            next_wordSync2 = WORD_RESET;
        end
    end

    // Synchroniser and capture registers
    always_ff @(posedge sys_clk)
    begin
        latchSync <= next_latchSync;
        updSync   <= next_updSync;
        latchPrev <= next_latchPrev;
        updPrev   <= next_updPrev;
        wordSync1 <= next_wordSync1;
        wordSync2 <= next_wordSync2;
    end

    // Edge detection on synchronised strobes
    assign latchFall = latchPrev & ~latchSync[1];
    assign updFall   = updPrev & ~updSync[1];
    assign selChan   = wordSync2[SEL_MSB:SEL_LSB];

    // Staging latch: every accepted word lands in the selected channel
    always_comb
    begin
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            // Hold by default
            next_stageCode[i]  = stageCode[i];
            next_stageRange[i] = stageRange[i];
            if (latchFall && chanHit(selChan, i))
            begin
                next_stageCode[i]  = wordCode(wordSync2);
                next_stageRange[i] = wordRange(wordSync2);
            end
            // Defined start state
            if (rst)
            begin
                next_stageCode[i]  = CODE_RESET;
                next_stageRange[i] = RANGE_RESET;
            end
        end
    end

    // Staging latch registers
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            stageCode[i]  <= next_stageCode[i];
            stageRange[i] <= next_stageRange[i];
        end
    end

    // Output latch: transparent load, or refresh of all channels at once
    always_comb
    begin
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            // Hold by default
            next_outCode[i]  = outCode[i];
            next_outRange[i] = outRange[i];
            // Word goes straight through only while the update strobe is low
            if (latchFall && !updSync[1] && chanHit(selChan, i))
            begin
                next_outCode[i]  = wordCode(wordSync2);
                next_outRange[i] = wordRange(wordSync2);
            end
            // Falling update strobe copies staging, including a word taken this cycle
            if (updFall)
            begin
                next_outCode[i]  = next_stageCode[i];
                next_outRange[i] = next_stageRange[i];
            end
            // Defined start state
            if (rst)
            begin
                next_outCode[i]  = CODE_RESET;
                next_outRange[i] = RANGE_RESET;
            end
        end
    end

    // Output latch registers; data outputs come straight from these flops
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            outCode[i]  <= next_outCode[i];
            outRange[i] <= next_outRange[i];
        end
    end

    // Per-channel outputs, each its own code and span
    assign analog_out_a  = outCode[SEL_A];
    assign analog_out_b  = outCode[SEL_B];
    assign analog_out_c  = outCode[SEL_C];
    assign analog_out_d  = outCode[SEL_D];
    assign rangeDouble_a = outRange[SEL_A];
    assign rangeDouble_b = outRange[SEL_B];
    assign rangeDouble_c = outRange[SEL_C];
    assign rangeDouble_d = outRange[SEL_D];
endmodule : qdsl_loader

// ===== qdsl_chk.sv
// Purpose: Port assertions for the quad DAC loader
// Assumes: Strobe events are spaced by more than eight cycles
// Notes:   age counts cycles since the last strobe fall
`timescale 1ns/1ps
module qdsl_chk
    import qdsl_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 serialClk,
    input wire logic                 serialData,
    input wire logic                 wordLatch,
    input wire logic                 output_update_strobe,
    input wire logic [DATA_BITS-1:0] analog_out_a,
    input wire logic [DATA_BITS-1:0] analog_out_b,
    input wire logic [DATA_BITS-1:0] analog_out_c,
    input wire logic [DATA_BITS-1:0] analog_out_d,
    input wire logic                 rangeDouble_a,
    input wire logic                 rangeDouble_b,
    input wire logic                 rangeDouble_c,
    input wire logic                 rangeDouble_d
);
    logic [35:0] allOut;
    logic [3:0]  age;
    logic [3:0]  next_age;
    logic        prevLatch;
    logic        prevUpd;
    assign allOut = {rangeDouble_a, rangeDouble_b, rangeDouble_c, rangeDouble_d,
                     analog_out_a, analog_out_b, analog_out_c, analog_out_d};
    // Restart on a strobe fall, saturate at 15
    always_comb
    begin
        next_age = (age == 4'hF) ? 4'hF : age + 4'h1;
        if ((prevLatch && !wordLatch) || (prevUpd && !output_update_strobe))
            next_age = 4'h0;
    end
    // Register age and strobe history
    always_ff @(posedge sys_clk)
    begin
        age       <= rst ? 4'hF : next_age;
        prevLatch <= wordLatch;
        prevUpd   <= output_update_strobe;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence quiet; age > 4'h7; endsequence
    sequence gap; $stable(allOut)[*2]; endsequence
    sequence settled; $stable(allOut)[*4]; endsequence
    a_reset_zero: assert property (disable iff (1'b0) rst |=> allOut == 36'h0)
        else $error("outputs not cleared by reset");
    a_release_zero: assert property ($fell(rst) |-> allOut == 36'h0)
        else $error("outputs not zero after reset");
    a_hold_high: assert property (output_update_strobe[*7] |-> $stable(allOut))
        else $error("output moved while update strobe high");
    a_change_cause: assert property ($changed(allOut) |-> age == 4'h2)
        else $error("output moved without a strobe fall");
    a_latch_window: assert property (quiet ##0 $fell(wordLatch) |=> gap ##2 settled)
        else $error("latch update outside its window");
    a_update_window: assert property (quiet ##0 $fell(output_update_strobe) |=> gap ##2 settled)
        else $error("refresh not done in one step");
    a_rise_ignored: assert property (quiet ##0 $rose(output_update_strobe) |=> $stable(allOut)[*8])
        else $error("update strobe rise moved outputs");
    a_range_cause: assert property ($changed(allOut[35:32]) |-> age == 4'h2)
        else $error("range moved without a strobe fall");
endmodule : qdsl_chk

bind qdsl_loader qdsl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .serialClk(serialClk), .serialData(serialData),
    .wordLatch(wordLatch), .output_update_strobe(output_update_strobe), .analog_out_a(analog_out_a),
    .analog_out_b(analog_out_b), .analog_out_c(analog_out_c), .analog_out_d(analog_out_d),
    .rangeDouble_a(rangeDouble_a), .rangeDouble_b(rangeDouble_b), .rangeDouble_c(rangeDouble_c),
    .rangeDouble_d(rangeDouble_d));

// ===== qdsl_host.sv
// Purpose: Host model framing 11-bit words on the serial link
// Assumes: Link clock idles high and runs only within frames
// Notes:   Data line shows the inverse of its last bit after a frame
`timescale 1ns/1ps
module qdsl_host
(
    input  wire logic sys_clk,
    output logic      serialClk,
    output logic      serialData,
    output logic      wordLatch
);
    initial {serialClk, serialData, wordLatch} = 3'h5;
    // Shift select, range, data MSB first, then pulse the latch
    task automatic send(input logic [10:0] w, input int hold);
        for (int i = 10; i >= 0; i--)
        begin
            serialData = w[i];
            #7.5 serialClk = 1'b0;
            #7.5 serialClk = 1'b1;
        end
        serialData = ~w[0];
        repeat (4) @(posedge sys_clk);
        #1 wordLatch = 1'b0;
        repeat (hold) @(posedge sys_clk);
        #1 wordLatch = 1'b1;
    endtask : send
endmodule : qdsl_host

// ===== quad_dac_serial_loader_tb_top.sv
// Purpose: Self-checking bench for the quad DAC loader
// Assumes: Host model frames every word
// Notes:   Model keeps a staged and an output code per channel
`timescale 1ns/1ps
module quad_dac_serial_loader_tb_top;
    import qdsl_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 upd = 1'b0;
    wire logic            serialClk, serialData, wordLatch;
    logic [DATA_BITS-1:0] outA, outB, outC, outD;
    logic [3:0]           rng;
    logic [8:0]           seen [4];
    logic [8:0]           mS [4];
    logic [8:0]           mO [4];
    int                   failures = 0;
    int                   checked = 0;
    int                   cycles = 0;
    assign seen = '{{rng[0], outA}, {rng[1], outB}, {rng[2], outC}, {rng[3], outD}};
    always #10 sys_clk = ~sys_clk;
    qdsl_host u_host (.sys_clk(sys_clk), .serialClk(serialClk), .serialData(serialData), .wordLatch(wordLatch));
    qdsl_loader u_dut (.sys_clk(sys_clk), .rst(rst), .serialClk(serialClk), .serialData(serialData),
        .wordLatch(wordLatch), .output_update_strobe(upd), .analog_out_a(outA), .analog_out_b(outB),
        .analog_out_c(outC), .analog_out_d(outD), .rangeDouble_a(rng[0]), .rangeDouble_b(rng[1]),
        .rangeDouble_c(rng[2]), .rangeDouble_d(rng[3]));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t channel code %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic checkAll;
        for (int i = 0; i < 4; i++) chk(seen[i], mO[i]);
    endtask : checkAll
    // Load one word and track it in the model
    task automatic ld(input logic [10:0] w);
        u_host.send(w, 3 + $urandom % 4);
        repeat (6) @(posedge sys_clk);
        #1 mS[w[10:9]] = w[8:0];
        if (upd == 1'b0) mO[w[10:9]] = w[8:0];
        checkAll;
    endtask : ld
    task automatic doReset;
        #1 rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 4; i++) {mS[i], mO[i]} = 18'h0;
        checkAll;
    endtask : doReset
    task wrap_up;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Cycle ceiling against a hang
    always @(posedge sys_clk) if (++cycles == 3000) begin failures++; wrap_up; end
    initial
    begin
        void'($urandom(32'h33A58B1D));
        doReset;
        $display("test reset done");
        for (int i = 0; i < 8; i++) ld({i[1:0], 9'($urandom)});
        $display("test direct done");
        upd = 1'b1;
        for (int i = 3; i >= 0; i--) ld({i[1:0], 9'($urandom)});
        upd = 1'b0;
        repeat (7) @(posedge sys_clk);
        #1 for (int i = 0; i < 4; i++) mO[i] = mS[i];
        checkAll;
        $display("test deferred done");
        repeat (4) @(posedge sys_clk);
        doReset;
        ld({2'h2, 9'($urandom)});
        $display("test second reset done");
        wrap_up;
    end
endmodule : quad_dac_serial_loader_tb_top
